// *** shared/apt_pkg.sv ***
// Purpose: Constants and types for the periodic tick timer.
// Assumes: Classic Wishbone, 32-bit data, byte registers in the low lane.
// Notes:   Byte address of a register is four times its index.

package apt_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] APT_IDX_CTRL   = 6'h12;
	localparam logic [5:0] APT_IDX_TRIM   = 6'h13;
	localparam logic [5:0] APT_IDX_RATE_H = 6'h14;
	localparam logic [5:0] APT_IDX_RATE_L = 6'h15;
	localparam logic [5:0] APT_IDX_TEST   = 6'h16;
	localparam logic [5:0] APT_IDX_STAT   = 6'h20;
	localparam logic [5:0] APT_IDX_MASK   = 6'h21;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int APT_BIT_SRC  = 7;
	localparam int APT_BIT_WSEL = 4;
	localparam int APT_BIT_WEN  = 3;
	localparam int APT_BIT_EN   = 2;
	localparam int APT_BIT_IE   = 1;
	localparam int APT_BIT_FLAG = 0;
	localparam int APT_TRIM_LSB = 2;

	// ----------------------------------------
	// Reset values and counts
	// ----------------------------------------
	localparam logic [7:0]  APT_RST_CTRL = 8'h00;
	localparam logic [15:0] APT_RST_RATE = 16'h0000;
	localparam logic [5:0]  APT_RST_TRIM = 6'h00;
	localparam logic [7:0]  APT_RST_TEST = 8'h00;
	// Slow clock edges before the gate opens
	localparam logic [1:0]  APT_GATE_SYNC_EDGES = 2'h2;

	// Control register layout
	typedef struct packed {
		logic       src;
		logic [1:0] rsvd;
		logic       wsel;
		logic       wen;
		logic       en;
		logic       ie;
		logic       flag;
	} apt_ctrl_t;

endpackage : apt_pkg

// *** design/apt_timer.sv ***
// Purpose: Autonomous periodic tick timer with Wishbone register access.
// Assumes: Slow RC clock arrives as a pin and is far slower than i_core_clk.
// Notes:   All state freezes while i_clk_en is low.

`timescale 1ns/1ps

// What this block does
// - Control bit 7 picks slow RC clock (0) or bus clock (1).
// - Source bit changes only while disabled, not by the enabling write.
// - Wave select 0: one-tick high pulse at each period end.
// - Wave select 1: pin toggles each timeout, clock of twice the period.
// - Waveform reaches pin only with external enable and timer enable set.
// - Timer enable bit 2 starts counting; clearing it disables the timer.
// - Interrupt enable bit 1 makes flag raise interrupt request.
// - Flag bit 0 sets on timeout; write one clears, zero keeps.
// - Trim register bits 7-2 hold six-bit signed slow clock trim.
// - Trim -32 slowest, 0 mid, +31 fastest, monotonic in signed value.
// - Trim loads from nonvolatile value after reset release.
// - Rate value bytes writable only while timer is disabled.
// - Period is 2*(rate+1) bus cycles or 2*(rate+1)*2 slow cycles.
// - Slow source: first timeout delayed one to two slow cycles.
// - At 20KHz slow clock rate 0 is 0.2 ms, FFFF 13107.2 ms.
// - Test register readable always, writable only in special mode.
module apt_timer
	import apt_pkg::*;
(
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_clk_en,
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	input  wire logic        i_slow_rc_clk,
	input  wire logic        i_special_mode,
	input  wire logic [5:0]  i_nvm_trim,
	output logic             o_wb_ack,
	output logic [31:0]      o_wb_dat,
	output logic             o_irq,
	output logic             o_periodic_wave_pin,
	output logic [5:0]       o_slow_osc_trim
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------

	// Word index match; low two address bits are ignored
	function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
		reg_hit = (adr[7:2] == idx);
	endfunction : reg_hit

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	apt_ctrl_t   ctrl_reg;
	logic [15:0] rate_reg;
	logic [5:0]  trim_reg;
	logic        trim_loaded_reg;
	logic [7:0]  test_reg;
	logic        ack_reg;
	logic [31:0] rdat_reg;
	logic        irq_reg;
	logic        pin_reg;
	logic        rc_s1_reg;
	logic        rc_s2_reg;
	logic        rc_s3_reg;
	logic        sm_s1_reg;
	logic        sm_s2_reg;
	logic [1:0]  gate_cnt_reg;
	logic        presc_reg;
	logic [16:0] cnt_reg;
	logic        pulse_reg;
	logic        toggle_reg;
	logic        wb_req;
	logic        wr_en;
	logic        wr_lane0;
	logic [7:0]  wbyte;
	logic        rc_rise;
	logic        gate_open;
	logic        tick;
	logic [16:0] cnt_last;
	logic        timeout;
	logic        flag_clr;
	logic [7:0]  rd_byte;

	// ----------------------------------------
	// Bus request decode
	// ----------------------------------------

	// New request only while no answer is pending
	assign wb_req   = i_wb_cyc & i_wb_stb & ~ack_reg;
	assign wr_en    = wb_req & i_wb_we & i_clk_en;
	// Byte registers live in lane 0 only
	assign wr_lane0 = wr_en & i_wb_sel[0];
	assign wbyte    = i_wb_dat[7:0];

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------

	// Slow clock and mode pin are asynchronous to the core clock
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rc_s1_reg <= 1'b0;
			rc_s2_reg <= 1'b0;
			rc_s3_reg <= 1'b0;
			sm_s1_reg <= 1'b0;
			sm_s2_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			rc_s1_reg <= i_slow_rc_clk;
			rc_s2_reg <= rc_s1_reg;
			rc_s3_reg <= rc_s2_reg;
			sm_s1_reg <= i_special_mode;
			sm_s2_reg <= sm_s1_reg;
		end
	end

	// Edge detect looks only past the first stage
	assign rc_rise = rc_s2_reg & ~rc_s3_reg;

	// ----------------------------------------
	// Tick generation
	// ----------------------------------------

	// Gate release waits for slow edges, like a synchronous clock gate
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			gate_cnt_reg <= 2'h0;
		end
		else if (i_clk_en)
		begin
			if (!ctrl_reg.en || ctrl_reg.src)
			begin
				gate_cnt_reg <= 2'h0;
			end
			else if (rc_rise && !gate_open)
			begin
				gate_cnt_reg <= gate_cnt_reg + 2'h1;
			end
		end
	end

	assign gate_open = (gate_cnt_reg == APT_GATE_SYNC_EDGES);

	// Halves the slow clock; each tick is two slow periods
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			presc_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!ctrl_reg.en || !gate_open)
			begin
				presc_reg <= 1'b0;
			end
			else if (rc_rise)
			begin
				presc_reg <= ~presc_reg;
			end
		end
	end

	// Bus source ticks every enabled cycle
	assign tick = ctrl_reg.en & (ctrl_reg.src | (gate_open & rc_rise & presc_reg));

	// ----------------------------------------
	// Period counter
	// ----------------------------------------

	// Last count of 2*(rate+1) ticks; also gives the table's periods at 20KHz
	assign cnt_last = {rate_reg, 1'b1};
	assign timeout  = tick & (cnt_reg == cnt_last);

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			cnt_reg <= 17'h00000;
		end
		else if (i_clk_en)
		begin
			if (!ctrl_reg.en)
			begin
				cnt_reg <= 17'h00000;
			end
			else if (timeout)
			begin
				cnt_reg <= 17'h00000;
			end
			else if (tick)
			begin
				cnt_reg <= cnt_reg + 17'h00001;
			end
		end
	end

	// ----------------------------------------
	// Waveforms
	// ----------------------------------------

	// Pulse lasts one tick, half the minimum period
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pulse_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!ctrl_reg.en)
			begin
				pulse_reg <= 1'b0;
			end
			else if (timeout)
			begin
				pulse_reg <= 1'b1;
			end
			else if (tick)
			begin
				pulse_reg <= 1'b0;
			end
		end
	end

	// Toggle gives a clock of twice the period
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			toggle_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!ctrl_reg.en)
			begin
				toggle_reg <= 1'b0;
			end
			else if (timeout)
			begin
				toggle_reg <= ~toggle_reg;
			end
		end
	end

	// Pin follows the waveform one cycle later
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			pin_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			pin_reg <= ctrl_reg.en & ctrl_reg.wen & (ctrl_reg.wsel ? toggle_reg : pulse_reg);
		end
	end

	// ----------------------------------------
	// Control register
	// ----------------------------------------

	// Flag clear comes from control or status register
	assign flag_clr = wr_lane0 & wbyte[APT_BIT_FLAG]
		& (reg_hit(i_wb_adr, APT_IDX_CTRL) | reg_hit(i_wb_adr, APT_IDX_STAT));

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ctrl_reg <= apt_ctrl_t'(APT_RST_CTRL);
		end
		else if (i_clk_en)
		begin
			if (wr_lane0 && reg_hit(i_wb_adr, APT_IDX_CTRL))
			begin
				// Source may not move under a running counter
				if (!ctrl_reg.en && !wbyte[APT_BIT_EN])
				begin
					ctrl_reg.src <= wbyte[APT_BIT_SRC];
				end
				ctrl_reg.wsel <= wbyte[APT_BIT_WSEL];
				ctrl_reg.wen  <= wbyte[APT_BIT_WEN];
				ctrl_reg.en   <= wbyte[APT_BIT_EN];
				ctrl_reg.ie   <= wbyte[APT_BIT_IE];
			end
			else if (wr_lane0 && reg_hit(i_wb_adr, APT_IDX_MASK))
			begin
				ctrl_reg.ie <= wbyte[APT_BIT_FLAG];
			end
			// A timeout in the clearing cycle still sets the flag
			if (timeout)
			begin
				ctrl_reg.flag <= 1'b1;
			end
			else if (flag_clr)
			begin
				ctrl_reg.flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Rate, trim and test registers
	// ----------------------------------------

	// Rate is frozen while running so the count stays consistent
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			rate_reg <= APT_RST_RATE;
		end
		else if (i_clk_en && wr_lane0 && !ctrl_reg.en)
		begin
			if (reg_hit(i_wb_adr, APT_IDX_RATE_H))
			begin
				rate_reg[15:8] <= wbyte;
			end
			if (reg_hit(i_wb_adr, APT_IDX_RATE_L))
			begin
				rate_reg[7:0] <= wbyte;
			end
		end
	end

	// Trim is signed: the oscillator reads it as -32..+31
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			trim_reg        <= APT_RST_TRIM;
			trim_loaded_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			if (!trim_loaded_reg)
			begin
				trim_reg        <= i_nvm_trim;
				trim_loaded_reg <= 1'b1;
			end
			else if (wr_lane0 && reg_hit(i_wb_adr, APT_IDX_TRIM))
			begin
				trim_reg <= wbyte[7:APT_TRIM_LSB];
			end
		end
	end

	// Factory test byte has no effect on the timer
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			test_reg <= APT_RST_TEST;
		end
		else if (i_clk_en && wr_lane0 && sm_s2_reg && reg_hit(i_wb_adr, APT_IDX_TEST))
		begin
			test_reg <= wbyte;
		end
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------

	// Unmapped addresses read as zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (reg_hit(i_wb_adr, APT_IDX_CTRL))
		begin
			rd_byte = {ctrl_reg.src, 2'b00, ctrl_reg.wsel, ctrl_reg.wen,
				ctrl_reg.en, ctrl_reg.ie, ctrl_reg.flag};
		end
		else if (reg_hit(i_wb_adr, APT_IDX_TRIM))
		begin
			rd_byte = {trim_reg, 2'b00};
		end
		else if (reg_hit(i_wb_adr, APT_IDX_RATE_H))
		begin
			rd_byte = rate_reg[15:8];
		end
		else if (reg_hit(i_wb_adr, APT_IDX_RATE_L))
		begin
			rd_byte = rate_reg[7:0];
		end
		else if (reg_hit(i_wb_adr, APT_IDX_TEST))
		begin
			rd_byte = test_reg;
		end
		else if (reg_hit(i_wb_adr, APT_IDX_STAT))
		begin
			rd_byte = {7'h00, ctrl_reg.flag};
		end
		else if (reg_hit(i_wb_adr, APT_IDX_MASK))
		begin
			rd_byte = {7'h00, ctrl_reg.ie};
		end
	end

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------

	// One wait state; ack drops the cycle after it is given
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h00000000;
		end
		else if (i_clk_en)
		begin
			ack_reg <= wb_req;
			if (wb_req && !i_wb_we)
			begin
				rdat_reg <= {24'h000000, rd_byte};
			end
		end
	end

	// ----------------------------------------
	// Interrupt
	// ----------------------------------------

	// Registered, so it trails the flag by one cycle
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			irq_reg <= 1'b0;
		end
		else if (i_clk_en)
		begin
			irq_reg <= ctrl_reg.flag & ctrl_reg.ie;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_wb_ack            = ack_reg;
	assign o_wb_dat            = rdat_reg;
	assign o_irq               = irq_reg;
	assign o_periodic_wave_pin = pin_reg;
	assign o_slow_osc_trim     = trim_reg;

endmodule : apt_timer

// *** verif/apt_timer_chk.sv ***
// Purpose: Port-level assertions for apt_timer.
// Assumes: i_clk_en stays high while checked.
// Notes:   A shadow follows control and mask writes.
`timescale 1ns/1ps
module apt_timer_chk
	import apt_pkg::*;
(
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic        i_clk_en,
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic [3:0]  i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic [5:0]  i_nvm_trim,
	input wire logic        o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	input wire logic        o_irq,
	input wire logic        o_periodic_wave_pin,
	input wire logic [5:0]  o_slow_osc_trim
);
	// --------------------------
	// Shadows
	// --------------------------
	logic      req;
	logic      wr;
	logic      seen_reg;
	apt_ctrl_t ctl_reg;
	// A write lands at the edge it is taken
	assign req = i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en;
	assign wr  = req && i_wb_we && i_wb_sel[0];
	// Marks the edge where the trim loads
	always_ff @(posedge i_core_clk or negedge i_nrst)
		if (!i_nrst)
			seen_reg <= 1'b0;
		else
			seen_reg <= 1'b1;
	// Source moves only while off
	always_ff @(posedge i_core_clk or negedge i_nrst)
		if (!i_nrst)
			ctl_reg <= APT_RST_CTRL;
		else if (wr && i_wb_adr[7:2] == APT_IDX_CTRL)
		begin
			ctl_reg.en   <= i_wb_dat[APT_BIT_EN];
			ctl_reg.ie   <= i_wb_dat[APT_BIT_IE];
			ctl_reg.wsel <= i_wb_dat[APT_BIT_WSEL];
			if (!ctl_reg.en && !i_wb_dat[APT_BIT_EN])
				ctl_reg.src <= i_wb_dat[APT_BIT_SRC];
		end
		else if (wr && i_wb_adr[7:2] == APT_IDX_MASK)
			ctl_reg.ie <= i_wb_dat[0];

	// --------------------------
	// Properties
	// --------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_nrst);
	a_ack_after_req: assert property (req |=> o_wb_ack)
		else $error("no ack after request");
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	a_read_upper: assert property (o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_trim_load: assert property (!seen_reg |=> o_slow_osc_trim == $past(i_nvm_trim))
		else $error("trim not loaded after reset");
	a_trim_write: assert property (seen_reg && wr && i_wb_adr[7:2] == APT_IDX_TRIM
		|=> o_slow_osc_trim == $past(i_wb_dat[7:2])) else $error("trim write lost");
	a_irq_needs_ie: assert property (!ctl_reg.ie && !$past(ctl_reg.ie) |-> !o_irq)
		else $error("irq while disabled");
	a_pin_needs_en: assert property (!ctl_reg.en && !$past(ctl_reg.en) |-> !o_periodic_wave_pin)
		else $error("pin driven while off");
	a_pulse_one: assert property ($rose(o_periodic_wave_pin) && ctl_reg.src && !ctl_reg.wsel
		|=> !o_periodic_wave_pin) else $error("pulse too long");
	cover property (o_irq);
	cover property ($rose(o_periodic_wave_pin) && !ctl_reg.wsel);
	cover property ($changed(o_periodic_wave_pin) && ctl_reg.wsel);
endmodule : apt_timer_chk

// *** verif/apt_timer_bench.sv ***
// Purpose: Self-checking bench for apt_timer.
// Assumes: Slow clock free-running at 16 core cycles.
// Notes:   Slow-source periods allow sync jitter.
`timescale 1ns/1ps
module apt_timer_bench
	import apt_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic        sm = 1'b0;
	logic        slw = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [5:0]  nvm = 6'h00;
	logic [7:0]  rv;
	wire         ack;
	wire         irq;
	wire         pin;
	wire  [31:0] rdat;
	wire  [5:0]  trim;
	int          err_count = 0;
	int          check_count = 0;

	// --------------------------
	// Clocks and device
	// --------------------------
	always #50 clk = ~clk;
	always #800 slw = ~slw;
	apt_timer u_dut (.i_core_clk(clk), .i_nrst(rst_n), .i_clk_en(1'b1), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wd), .i_slow_rc_clk(slw),
		.i_special_mode(sm), .i_nvm_trim(nvm), .o_wb_ack(ack), .o_wb_dat(rdat), .o_irq(irq),
		.o_periodic_wave_pin(pin), .o_slow_osc_trim(trim));

	// --------------------------
	// Tasks
	// --------------------------
	task automatic results();
		if (err_count == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Hold until ack is sampled, then idle a cycle
	task automatic wb(input logic w, input logic [5:0] ix, input logic [7:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= {ix, 2'h0};
		wd  <= {24'h000000, d};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rv = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		chk("ack", 32'h1, 32'(n < 50));
		if (n >= 50)
			results();
	endtask : wb
	// Cycles until the pin moves, bounded
	task automatic chg(output int c);
		logic p;
		p = pin;
		c = 0;
		do
		begin
			@(posedge clk);
			c++;
		end
		while (pin === p && c < 2000);
		chk("pin moves", 32'h1, 32'(c < 2000));
		if (c >= 2000)
			results();
	endtask : chg
	// Pulse mode aligns on a rise and spans two moves
	task automatic period(input int w, output int c);
		int t;
		chg(t);
		if (w == 0 && pin !== 1'b1)
			chg(t);
		chg(c);
		if (w == 0)
		begin
			chg(t);
			c += t;
		end
	endtask : period

	// --------------------------
	// Sequence
	// --------------------------
	initial
	begin
		logic [5:0] ix [5];
		logic [7:0] ex [5];
		int r, c, e, t1, t2, hi;
		void'($urandom(55493));
		nvm <= 6'($urandom);
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		chk("trim out", 32'(nvm), 32'(trim));
		wb(1, 6'h3f, 8'hff);
		ix = '{APT_IDX_CTRL, APT_IDX_RATE_L, APT_IDX_TEST, APT_IDX_TRIM, 6'h3f};
		ex = '{APT_RST_CTRL, APT_RST_RATE[7:0], APT_RST_TEST, {nvm, 2'h0}, 8'h00};
		foreach (ix[k])
		begin
			wb(0, ix[k], 8'h00);
			chk("reset value", 32'(ex[k]), 32'(rv));
		end
		r = $urandom;
		wb(1, APT_IDX_TRIM, 8'(r));
		wb(0, APT_IDX_TRIM, 8'h00);
		chk("trim reg", {24'h0, r[7:2], 2'h0}, 32'(rv));
		chk("trim out", 32'(r[7:2]), 32'(trim));
		for (int m = 0; m < 2; m++)
		begin
			sm <= m[0];
			repeat (4) @(posedge clk);
			wb(1, APT_IDX_TEST, 8'h5a);
			wb(0, APT_IDX_TEST, 8'h00);
			chk("test reg", m ? 32'h5a : 32'h0, 32'(rv));
		end
		// Each source with each waveform
		for (int s = 1; s >= 0; s--)
			for (int w = 1; w >= 0; w--)
			begin
				r = s ? $urandom_range(6) : $urandom_range(1);
				e = (s ? 2 : 64) * (r + 1);
				wb(1, APT_IDX_RATE_L, 8'(r));
				wb(1, APT_IDX_CTRL, {s[0], 7'h00});
				wb(1, APT_IDX_CTRL, {s[0], 2'h0, w[0], 4'h6});
				hi = 0;
				repeat (3 * e)
				begin
					@(posedge clk);
					if (pin !== 1'b0)
						hi++;
				end
				chk("pin hidden", 32'h0, 32'(hi));
				wb(1, APT_IDX_CTRL, {~s[0], 2'h0, w[0], 4'he});
				wb(1, APT_IDX_RATE_L, 8'(r + 1));
				repeat (2)
				begin
					period(w, c);
					if (s == 0 && c >= e - 3 && c <= e + 3)
						c = e;
					chk("period", 32'(e), 32'(c));
				end
				chk("irq", 32'h1, 32'(irq));
				wb(0, APT_IDX_CTRL, 8'h00);
				chk("ctrl", 32'({s[0], 2'h0, w[0], 4'hf}), 32'(rv));
				wb(0, APT_IDX_RATE_L, 8'h00);
				chk("rate", 32'(r), 32'(rv));
				wb(1, APT_IDX_MASK, 8'h00);
				chk("irq masked", 32'h0, 32'(irq));
				wb(0, APT_IDX_MASK, 8'h00);
				chk("mask", 32'h0, 32'(rv));
				wb(0, APT_IDX_STAT, 8'h00);
				chk("stat set", 32'h1, 32'(rv));
				wb(1, APT_IDX_CTRL, {s[0], 2'h0, w[0], 4'h8});
				wb(1, APT_IDX_CTRL, {s[0], 2'h0, w[0], 4'h9});
				wb(0, APT_IDX_CTRL, 8'h00);
				chk("ctrl off", 32'({s[0], 2'h0, w[0], 4'h8}), 32'(rv));
				chk("pin off", 32'h0, 32'(pin));
			end
		// Re-enable mid-period restarts a full period
		r = 4 + $urandom_range(4);
		wb(1, APT_IDX_RATE_L, 8'(r));
		wb(1, APT_IDX_CTRL, 8'h80);
		wb(1, APT_IDX_CTRL, 8'h9c);
		chg(t1);
		repeat (r) @(posedge clk);
		wb(1, APT_IDX_CTRL, 8'h98);
		wb(1, APT_IDX_CTRL, 8'h9c);
		chg(t2);
		chk("first period", 32'(t1), 32'(t2));
		// Clear through the status alias once the timer is stopped
		wb(1, APT_IDX_CTRL, 8'h98);
		wb(1, APT_IDX_STAT, 8'h01);
		wb(0, APT_IDX_STAT, 8'h00);
		chk("stat clear", 32'h0, 32'(rv));
		results();
	end
endmodule : apt_timer_bench

bind apt_timer apt_timer_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
	.i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
	.i_wb_dat(i_wb_dat), .i_nvm_trim(i_nvm_trim), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_irq(o_irq),
	.o_periodic_wave_pin(o_periodic_wave_pin), .o_slow_osc_trim(o_slow_osc_trim));
